// ---- flash_gate_pkg.sv ----
/*
  Constants shared by the flash program/erase gate: register offsets,
  field positions, reset values and the array-select key.
  Assumes a byte-wide register port with small word offsets.
*/
package flash_gate_pkg;

  // ==========================================================
  // Register offsets on the plain register port
  // ==========================================================
  localparam logic [3:0] OFF_MODE_CONTROL = 4'h0;  // Mode control
  localparam logic [3:0] OFF_BLOCK_LOW = 4'h1;     // Block select, low
  localparam logic [3:0] OFF_BLOCK_HIGH = 4'h2;    // Block select, high
  localparam logic [3:0] OFF_ARRAY_SELECT = 4'h3;  // Array select
  localparam logic [3:0] OFF_STATUS = 4'h4;        // Switch status

  // ==========================================================
  // Mode control field positions
  // ==========================================================
  localparam int BIT_HW_GATE = 7;       // Pin mirror, read only
  localparam int BIT_SW_GATE = 6;       // Software enable
  localparam int BIT_ERASE_SETUP = 5;
  localparam int BIT_PROGRAM_SETUP = 4;
  localparam int BIT_ERASE_VERIFY = 3;
  localparam int BIT_PROGRAM_VERIFY = 2;
  localparam int BIT_ERASE_GO = 1;
  localparam int BIT_PROGRAM_GO = 0;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] MODE_RESET_PIN_HIGH = 8'h80;
  localparam logic [7:0] MODE_RESET_PIN_LOW = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] BLOCK_HIGH_MASK = 4'hf;  // Four valid bits

  // ==========================================================
  // Array switching
  // ==========================================================
  localparam logic [7:0] ARRAY_SWITCH_KEY = 8'haa;  // Arbitrary key value
  localparam logic [3:0] SWITCH_SETTLE_CYCLES = 4'h8;  // Settle time; busy lasts one cycle more

  // Switch sequencer states, Gray along idle -> settle -> done
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_SETTLE = 2'b01,
    SW_DONE = 2'b11
  } switch_state_t;

endpackage

// ---- array_switch.sv ----
/*
  Array switchover sequencer: toggles the mapped array on a start pulse
  and holds busy for a fixed settle time.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module array_switch (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic start_i,   // One-cycle switch request
  output logic boot_mapped_o, // 1: boot array mapped in
  output logic busy_o         // Switch in progress
);
  import flash_gate_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  switch_state_t state;       // Sequencer state
  switch_state_t next_state;
  logic [3:0] count;          // Settle counter
  logic [3:0] next_count;
  logic boot_mapped;          // Current mapping
  logic next_boot_mapped;

  // Next-state logic; requests during a switch are dropped
  always_comb begin
    next_state = state;
    next_count = count;
    next_boot_mapped = boot_mapped;
    case (state)
      SW_IDLE: begin
        if (start_i) begin
          next_boot_mapped = ~boot_mapped;
          next_count = SWITCH_SETTLE_CYCLES;
          next_state = SW_SETTLE;
        end
      end
      SW_SETTLE: begin
        // Arrays unstable until the count runs out
        next_count = count - 4'h1;
        if (count == 4'h1) begin
          next_state = SW_DONE;
        end
      end
      SW_DONE: begin
        next_state = SW_IDLE;
      end
      default: begin
        next_state = SW_IDLE;
      end
    endcase
  end

  // Registers; the block boots with the boot array mapped
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state <= SW_IDLE;
      count <= 4'h0;
      boot_mapped <= 1'b1;
    end else begin
      state <= next_state;
      count <= next_count;
      boot_mapped <= next_boot_mapped;
    end
  end

  assign boot_mapped_o = boot_mapped;
  assign busy_o = (state != SW_IDLE);
endmodule
`default_nettype wire

// ---- flash_program_erase_gate.sv ----
/*
  Flash program/erase gate: mode control register with hardware and
  software write protection, block select registers, and array
  switching for user boot mode.
  Assumes a synchronous byte-wide register port and a pin level that is
  already synchronous to clock_i.
*/
//
// Overview of operation
// RL1: Software enable writable only while pin high
// RL2: Setup and verify bits need both enables
// RL3: Erase go needs enables and erase setup
// RL4: Program go needs enables and program setup
// RL5: Bit 7 reads the write-enable pin
// RL6: Software sets enable before other control bits
// RL7: With enable set, reads only in verify
// RL8: User boot maps boot array, hides user
// RL9: Software runs outside flash, switches back
// RL10: Only the key value triggers array switch
// RL11: No array access until switch completes
// RL12: Reset and standby give 80 or 00
// RL13: Software follows setup then go order
// RL14: Flash disabled reads zero, ignores writes; code zeroes mode control reads only and still takes key writes
// RL15: Blocked bits hold, others still update
//
`timescale 1ns/1ns
`default_nettype none
module flash_program_erase_gate (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic standby_i,            // Either standby mode, held
  input wire logic hw_program_gate_i,    // Write-enable pin level
  input wire logic flash_enabled_i,      // On-chip flash in use
  input wire logic user_boot_mode_i,     // Running in user boot mode
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire logic flash_read_req_i,     // CPU read of flash space
  output logic [7:0] rdata_o,
  output logic flash_read_allow_o,       // Array read permitted
  output logic boot_array_mapped_o,      // Boot array visible
  output logic switch_busy_o,            // Arrays unstable
  output logic sw_program_gate_o,
  output logic erase_setup_o,
  output logic program_setup_o,
  output logic erase_verify_o,
  output logic program_verify_o,
  output logic erase_go_o,
  output logic program_go_o,
  output logic [7:0] block_select_low_o,
  output logic [3:0] block_select_high_o
);
  import flash_gate_pkg::*;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Take a new bit value only when its gate is open
  function automatic logic gated(input logic allow, input logic old_v,
                                 input logic new_v);
    gated = allow ? new_v : old_v;
  endfunction

  // ==========================================================
  // Register state
  // ==========================================================
  logic [6:0] mode;             // Bits 6..0 of mode control
  logic [6:0] next_mode;
  logic [7:0] block_low;        // Block select low
  logic [7:0] next_block_low;
  logic [3:0] block_high;       // Block select high
  logic [3:0] next_block_high;
  logic [7:0] rdata;            // Registered read data
  logic [7:0] next_rdata;
  logic switch_start;           // Key write pulse
  logic boot_mapped;
  logic busy;

  logic [7:0] mode_view;        // Full register as software sees it
  logic wr_mode;
  logic sw_en;
  logic hw_en;

  assign hw_en = hw_program_gate_i;
  assign sw_en = mode[BIT_SW_GATE];
  assign wr_mode = write_i && flash_enabled_i && (addr_i == OFF_MODE_CONTROL);  // see RL14

  // Bit 7 mirrors the pin live; disabled flash reads zero
  always_comb begin
    mode_view = {hw_en, mode};  // see RL5
    if (!flash_enabled_i) begin
      mode_view = ZERO_BYTE;  // see RL14
    end
  end

  // ==========================================================
  // Mode control next values
  // ==========================================================
  // Each bit checks its own gate against the current state,
  // so a blocked bit holds while permitted ones update.
  always_comb begin
    next_mode = mode;
    if (wr_mode) begin
      // Software enable needs the pin
      next_mode[BIT_SW_GATE] = gated(hw_en, mode[BIT_SW_GATE], wdata_i[BIT_SW_GATE]);  // see RL1 see RL15
      // Setup and verify need both enables
      next_mode[BIT_ERASE_SETUP] = gated(hw_en && sw_en, mode[BIT_ERASE_SETUP],
                                         wdata_i[BIT_ERASE_SETUP]);  // see RL2
      next_mode[BIT_PROGRAM_SETUP] = gated(hw_en && sw_en, mode[BIT_PROGRAM_SETUP],
                                           wdata_i[BIT_PROGRAM_SETUP]);  // see RL2
      next_mode[BIT_ERASE_VERIFY] = gated(hw_en && sw_en, mode[BIT_ERASE_VERIFY],
                                          wdata_i[BIT_ERASE_VERIFY]);  // see RL2
      next_mode[BIT_PROGRAM_VERIFY] = gated(hw_en && sw_en, mode[BIT_PROGRAM_VERIFY],
                                            wdata_i[BIT_PROGRAM_VERIFY]);  // see RL2
      // Go bits also need their setup bit already set
      next_mode[BIT_ERASE_GO] = gated(hw_en && sw_en && mode[BIT_ERASE_SETUP],
                                      mode[BIT_ERASE_GO], wdata_i[BIT_ERASE_GO]);  // see RL3
      next_mode[BIT_PROGRAM_GO] = gated(hw_en && sw_en && mode[BIT_PROGRAM_SETUP],
                                        mode[BIT_PROGRAM_GO], wdata_i[BIT_PROGRAM_GO]);  // see RL4
    end
  end

  // ==========================================================
  // Block select next values
  // ==========================================================
  // Block selects follow the same software enable as the setup bits
  always_comb begin
    next_block_low = block_low;
    next_block_high = block_high;
    if (write_i && flash_enabled_i && hw_en && sw_en) begin
      if (addr_i == OFF_BLOCK_LOW) begin
        next_block_low = wdata_i;
      end
      if (addr_i == OFF_BLOCK_HIGH) begin
        next_block_high = wdata_i[3:0] & BLOCK_HIGH_MASK;
      end
    end
  end

  // Only the exact key starts a switch, and only while idle
  assign switch_start = write_i && (addr_i == OFF_ARRAY_SELECT)
                        && (wdata_i == ARRAY_SWITCH_KEY) && !busy;  // see RL10

  // ==========================================================
  // Read mux
  // ==========================================================
  // Unmapped offsets read zero
  always_comb begin
    next_rdata = ZERO_BYTE;
    if (read_i) begin
      case (addr_i)
        OFF_MODE_CONTROL: begin
          next_rdata = mode_view;
        end
        OFF_BLOCK_LOW: begin
          next_rdata = block_low;
        end
        OFF_BLOCK_HIGH: begin
          next_rdata = {4'h0, block_high};
        end
        OFF_ARRAY_SELECT: begin
          next_rdata = {7'h00, boot_mapped};
        end
        OFF_STATUS: begin
          next_rdata = {6'h00, busy, boot_mapped};
        end
        default: begin
          next_rdata = ZERO_BYTE;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  // Standby clears like reset; bit 7 is the pin so 80/00 follows
  always_ff @(posedge clock_i) begin
    if (reset_i || standby_i) begin
      mode <= 7'h00;  // see RL12
      block_low <= ZERO_BYTE;
      block_high <= 4'h0;
      rdata <= ZERO_BYTE;
    end else begin
      mode <= next_mode;
      block_low <= next_block_low;
      block_high <= next_block_high;
      rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Array switch sequencer
  // ==========================================================
  array_switch i_array_switch (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .start_i(switch_start),
    .boot_mapped_o(boot_mapped),
    .busy_o(busy)
  );

  // ==========================================================
  // Flash read gating
  // ==========================================================
  // Enable set: verify modes only; blocked during a switch as well
  assign flash_read_allow_o = flash_read_req_i && flash_enabled_i && !busy
                              && (!sw_en || mode[BIT_ERASE_VERIFY]
                                  || mode[BIT_PROGRAM_VERIFY]);  // see RL7
  // Boot array visible in user boot mode unless switched away
  assign boot_array_mapped_o = user_boot_mode_i && boot_mapped;  // see RL8
  assign switch_busy_o = busy;

  assign rdata_o = rdata;
  assign sw_program_gate_o = mode[BIT_SW_GATE];
  assign erase_setup_o = mode[BIT_ERASE_SETUP];
  assign program_setup_o = mode[BIT_PROGRAM_SETUP];
  assign erase_verify_o = mode[BIT_ERASE_VERIFY];
  assign program_verify_o = mode[BIT_PROGRAM_VERIFY];
  assign erase_go_o = mode[BIT_ERASE_GO];
  assign program_go_o = mode[BIT_PROGRAM_GO];
  assign block_select_low_o = block_low;
  assign block_select_high_o = block_high;
endmodule
`default_nettype wire

// ---- fpeg_chk.sv ----
/* Assertions on the ports of the flash program/erase gate.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module fpeg_chk
  import flash_gate_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic standby_i,
  input wire logic hw_program_gate_i,
  input wire logic flash_enabled_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire logic [7:0] rdata_o,
  input wire logic flash_read_allow_o,
  input wire logic switch_busy_o,
  input wire logic sw_program_gate_o,
  input wire logic erase_setup_o,
  input wire logic program_setup_o,
  input wire logic erase_verify_o,
  input wire logic program_verify_o,
  input wire logic erase_go_o,
  input wire logic program_go_o
);
  // ====================
  // Helpers
  // ====================
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // Mode write that the flash-enable lets through
  wire mw = write_i && addr_i == OFF_MODE_CONTROL && flash_enabled_i;
  // Both enables present before the write
  wire hs = hw_program_gate_i && sw_program_gate_o;
  // Key write to the array select register
  wire kw = write_i && addr_i == OFF_ARRAY_SELECT && wdata_i == ARRAY_SWITCH_KEY;
  // Busy spans settle plus done, then drops
  sequence s_settle;
    switch_busy_o[*8] ##1 switch_busy_o ##1 !switch_busy_o;
  endsequence
  // ====================
  // Properties
  // ====================
  property p_sw; $rose(sw_program_gate_o) |-> $past(mw && hw_program_gate_i); endproperty
  a_sw: assert property (p_sw)
    else $error("software enable set while pin low");
  property p_setup;
    $rose(erase_setup_o) || $rose(program_setup_o) || $rose(erase_verify_o) || $rose(program_verify_o)
      |-> $past(mw && hs);
  endproperty
  a_setup: assert property (p_setup)
    else $error("setup or verify bit set without enables");
  property p_ego; $rose(erase_go_o) |-> $past(mw && hs && erase_setup_o); endproperty
  a_ego: assert property (p_ego)
    else $error("erase go set without erase setup");
  property p_pgo; $rose(program_go_o) |-> $past(mw && hs && program_setup_o); endproperty
  a_pgo: assert property (p_pgo)
    else $error("program go set without program setup");
  // Standby clears the read register, so reads in standby are left out
  property p_pin;
    read_i && addr_i == OFF_MODE_CONTROL && !standby_i
      |=> rdata_o[7] == $past(hw_program_gate_i && flash_enabled_i);
  endproperty
  a_pin: assert property (p_pin)
    else $error("mode bit 7 differs from pin");
  property p_rgate; flash_read_allow_o && sw_program_gate_o |-> erase_verify_o || program_verify_o; endproperty
  a_rgate: assert property (p_rgate)
    else $error("array read allowed outside verify");
  property p_key; $rose(switch_busy_o) |-> $past(kw); endproperty
  a_key: assert property (p_key)
    else $error("switch started without key write");
  property p_settle; $rose(switch_busy_o) |-> s_settle; endproperty
  a_settle: assert property (p_settle)
    else $error("switch busy length wrong");
  property p_stby; standby_i |=> !sw_program_gate_o && !erase_go_o && !program_go_o; endproperty
  a_stby: assert property (p_stby)
    else $error("standby left mode bits set");
endmodule
bind flash_program_erase_gate fpeg_chk i_fpeg_chk (.clock_i(clock_i), .reset_i(reset_i),
  .standby_i(standby_i), .hw_program_gate_i(hw_program_gate_i), .flash_enabled_i(flash_enabled_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
  .flash_read_allow_o(flash_read_allow_o), .switch_busy_o(switch_busy_o),
  .sw_program_gate_o(sw_program_gate_o), .erase_setup_o(erase_setup_o),
  .program_setup_o(program_setup_o), .erase_verify_o(erase_verify_o),
  .program_verify_o(program_verify_o), .erase_go_o(erase_go_o), .program_go_o(program_go_o));
`default_nettype wire

// ---- flash_cpu_model.sv ----
/* Model of the CPU side that reads the flash array.
   Assumes busy comes straight from the gate. */
`timescale 1ns/1ns
`default_nettype none
module flash_cpu_model (
  input wire logic want_i,  // Program wants an array read
  input wire logic busy_i,  // Arrays being swapped
  output logic req_o        // Read request to the gate
);
  // Hold reads off mid-switch; the arrays are unstable then
  assign req_o = want_i && !busy_i;
endmodule
`default_nettype wire

// ---- flash_program_erase_gate_tb.sv ----
/* Self-checking bench for the flash program/erase gate.
   Assumes the checker is bound and the CPU model issues array reads. */
`timescale 1ns/1ns
`default_nettype none
module flash_program_erase_gate_tb;
  import flash_gate_pkg::*;
  // ====================
  // Stimulus and observed signals
  // ====================
  logic clk = 0, rst = 1, stby = 0, pin = 1, fen = 1, ubm = 0, wr = 0, rd = 0, want = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, bl;
  logic [3:0] bh;
  logic allow, boot, busy, sw, erase_setup, program_setup, ev, pv, ego, pgo, req;
  int fail_count = 0, compares = 0, n;
  localparam logic [3:0] MC = OFF_MODE_CONTROL;
  always #5 clk = ~clk;  // 100 MHz
  flash_program_erase_gate i_flash_program_erase_gate (.clock_i(clk), .reset_i(rst),
    .standby_i(stby), .hw_program_gate_i(pin), .flash_enabled_i(fen), .user_boot_mode_i(ubm),
    .addr_i(addr), .wdata_i(wdata), .write_i(wr), .read_i(rd), .flash_read_req_i(req),
    .rdata_o(rdata), .flash_read_allow_o(allow), .boot_array_mapped_o(boot),
    .switch_busy_o(busy), .sw_program_gate_o(sw), .erase_setup_o(erase_setup), .program_setup_o(program_setup),
    .erase_verify_o(ev), .program_verify_o(pv), .erase_go_o(ego), .program_go_o(pgo),
    .block_select_low_o(bl), .block_select_high_o(bh));
  flash_cpu_model i_flash_cpu_model (.want_i(want), .busy_i(busy), .req_o(req));
  // ====================
  // Tasks
  // ====================
  // Compare one byte, count and report
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One-cycle register write
  task automatic wt(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  // One-cycle read; data stands only in the next cycle
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, e);
  endtask
  // Bounded wait for the switchover to end
  task automatic settle;
    n = 0;
    while (busy === 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    chk(n[7:0], 8'h09);
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog well past the expected run
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    end_of_test;
  end
  // ====================
  // Main sequence
  // ====================
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    rc(MC, 8'h80);
    @(posedge clk) pin <= 0;
    wt(MC, 8'h40);
    rc(MC, 8'h00);
    @(posedge clk) pin <= 1;
    wt(MC, 8'h7f);
    rc(MC, 8'hc0);
    wt(MC, 8'h63);
    rc(MC, 8'he0);
    wt(MC, 8'h63);
    rc(MC, 8'he2);
    wt(MC, 8'h53);
    rc(MC, 8'hd2);
    wt(MC, 8'h53);
    rc(MC, 8'hd3);
    chk(8'({sw, erase_setup, program_setup, ev, pv, ego, pgo}), 8'h53);
    // Read gating by verify mode
    wt(MC, 8'h40);
    want <= 1;
    #1 chk(8'(allow), 8'h00);
    wt(MC, 8'h48);
    #1 chk(8'(allow), 8'h01);
    chk(8'({ev, pv}), 8'h02);
    wt(MC, 8'h44);
    #1 chk(8'(allow), 8'h01);
    chk(8'({ev, pv}), 8'h01);
    wt(OFF_BLOCK_LOW, 8'ha5);
    wt(OFF_BLOCK_HIGH, 8'hff);
    rc(OFF_BLOCK_LOW, 8'ha5);
    rc(OFF_BLOCK_HIGH, 8'h0f);
    chk(8'(bh), 8'h0f);
    chk(bl, 8'ha5);
    wt(4'hf, 8'h12);
    rc(4'hf, 8'h00);
    // Flash disabled: reads zero, writes dropped
    @(posedge clk) fen <= 0;
    rc(MC, 8'h00);
    wt(MC, 8'h00);
    @(posedge clk) fen <= 1;
    #1 chk(8'(sw), 8'h01);
    @(posedge clk) stby <= 1;
    @(posedge clk) stby <= 0;
    rc(MC, 8'h80);
    chk(bl, 8'h00);
    // Software enable now clear: block select writes are dropped
    wt(OFF_BLOCK_LOW, 8'h3c);
    rc(OFF_BLOCK_LOW, 8'h00);
    // Array switching in user boot mode
    @(posedge clk) ubm <= 1;
    wt(OFF_ARRAY_SELECT, 8'h55);
    #1 chk(8'({busy, boot}), 8'h01);
    wt(OFF_ARRAY_SELECT, ARRAY_SWITCH_KEY);
    #1 chk(8'({busy, req, allow, boot}), 8'h08);
    settle;
    chk(8'({allow, boot}), 8'h02);
    rc(OFF_STATUS, 8'h00);
    rc(OFF_ARRAY_SELECT, 8'h00);
    wt(OFF_ARRAY_SELECT, ARRAY_SWITCH_KEY);
    #1 settle;
    chk(8'(boot), 8'h01);
    rc(OFF_STATUS, 8'h01);
    @(posedge clk) ubm <= 0;
    #1 chk(8'(boot), 8'h00);
    end_of_test;
  end
endmodule
`default_nettype wire
